// ### hw/afc_host.sv
// Host controller for a strobed 9-bit asynchronous FIFO, driven over APB.
// Assumes the FIFO pins are synchronous to pclk and the straps match CTRL.
// Functional notes
// - After power-up pulse clear low; pointers zero, empty low, full and half high.
// - Write starts at write strobe fall while not full; data taken at rise.
// - Rewind only under 2047 writes since clear; reads resume after recovery.
// - Write strobe held low while full completes after the next read rise.
// - Read strobe held low while empty completes after the next write rise.
// - Width grows in nine-bit steps with shared controls, one flag set watched.
// - Lead device select low on first device; others high; only lead works.
// - Cascade: overall flags are ORed; half flag and rewind unavailable.
`timescale 1ns/1ps
`include "afc_map.svh"
module afc_host #(
  // One nine-bit slice; wider words share every control pin.
  parameter int DATA_W = `AFC_DATA_W,
  parameter bit LEAD_DEVICE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic write_strobe_n,
  output logic [DATA_W-1:0] write_data_in,
  output logic read_strobe_n,
  input wire logic [DATA_W-1:0] read_data_out,
  output logic clear_pulse_n,
  output logic rewind_strobe_n,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic half_level_flag_n
);
  // ========================================================================
  // Cycle counts: least times round up, flag delays folded into recovery.
  localparam int PW_CYC = (`AFC_T_PW_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS;
  localparam int ACC_CYC = (`AFC_T_ACC_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS;
  localparam int RDPW_CYC = (ACC_CYC > PW_CYC) ? ACC_CYC : PW_CYC;
  localparam int REC_NS = (`AFC_T_FLAG_NS > `AFC_T_REC_NS) ? `AFC_T_FLAG_NS : `AFC_T_REC_NS;
  localparam int REC_CYC = (REC_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS;
  localparam int FLOW_CYC = (`AFC_T_FLOW_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS;
  localparam int RSP_CYC = (`AFC_T_RSP_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS;
  localparam int RSR_CYC = (`AFC_T_RSR_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS;
  localparam int RWD_CYC = (`AFC_T_RWD_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS;
  localparam int RWD_REC_CYC = (`AFC_T_RWD_REC_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS;

  logic setup_ph;
  logic acc;
  logic wr_busy;
  logic rd_busy;
  logic clr_busy;
  logic rwd_busy;
  logic wr_take;
  logic rd_take;
  logic rwd_pulse_n;
  logic cascade;
  logic clr_pending;
  logic rd_pending;
  logic rwd_pending;
  logic rd_valid;
  logic rwd_refused;
  logic [DATA_W-1:0] rdata;
  logic [`AFC_WCOUNT_W-1:0] wcount;
  logic ctrl_wr;
  logic wdata_wr;
  logic status_wr;
  logic rdata_rd;
  logic clr_start;
  logic rd_start;
  logic rwd_start;
  logic rwd_ok;
  logic [31:0] next_prdata;

  // ========================================================================
  // APB decode; only a data write can stall, while a write or clear runs.
  assign setup_ph = psel && !penable;
  assign acc = psel && penable && pready;
  assign pready = !(pwrite && paddr == `AFC_ADDR_WDATA)
                  || (!wr_busy && !clr_pending && !clr_busy);
  assign pslverr = psel && penable && !(paddr == `AFC_ADDR_CTRL || paddr == `AFC_ADDR_STATUS
                   || paddr == `AFC_ADDR_WDATA || paddr == `AFC_ADDR_RDATA
                   || paddr == `AFC_ADDR_WCOUNT);
  assign ctrl_wr = acc && pwrite && paddr == `AFC_ADDR_CTRL;
  assign wdata_wr = acc && pwrite && paddr == `AFC_ADDR_WDATA;
  assign status_wr = acc && pwrite && paddr == `AFC_ADDR_STATUS;
  assign rdata_rd = acc && !pwrite && paddr == `AFC_ADDR_RDATA;

  // Read mux, sampled in the setup cycle so prdata comes from a flop.
  always_comb begin
    next_prdata = 32'h0;
    case (paddr)
      `AFC_ADDR_CTRL: next_prdata[`AFC_CTRL_CASCADE] = cascade;
      `AFC_ADDR_STATUS: begin
        next_prdata[`AFC_ST_EMPTY_N] = empty_flag_n;
        next_prdata[`AFC_ST_FULL_N] = full_flag_n;
        next_prdata[`AFC_ST_HALF_N] = cascade || half_level_flag_n;
        next_prdata[`AFC_ST_WR_BUSY] = wr_busy;
        next_prdata[`AFC_ST_RD_BUSY] = rd_busy;
        next_prdata[`AFC_ST_CLR_BUSY] = clr_busy || clr_pending;
        next_prdata[`AFC_ST_RWD_BUSY] = rwd_busy || rwd_pending;
        next_prdata[`AFC_ST_RD_VALID] = rd_valid;
        next_prdata[`AFC_ST_RWD_REFUSED] = rwd_refused;
      end
      `AFC_ADDR_WDATA: next_prdata[DATA_W-1:0] = write_data_in;
      `AFC_ADDR_RDATA: next_prdata[DATA_W-1:0] = rdata;
      `AFC_ADDR_WCOUNT: next_prdata[`AFC_WCOUNT_W-1:0] = wcount;
      default: next_prdata = 32'h0;
    endcase
  end

  // Read data register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup_ph) begin
      prdata <= next_prdata;
    end
  end

  // ========================================================================
  // Mode bit; it must match how the chain input is strapped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cascade <= 1'b0;
    end else if (ctrl_wr) begin
      cascade <= pwdata[`AFC_CTRL_CASCADE];
    end
  end

  // ========================================================================
  // Clear: pending from reset, so the first act after power-up is a clear.
  // Pending strobes are aborted so both are high before clear rises.
  assign clr_start = clr_pending && !wr_busy && !rd_busy && !rwd_busy && !clr_busy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_pending <= 1'b1;
    end else begin
      clr_pending <= (clr_pending && !clr_start) || (ctrl_wr && pwdata[`AFC_CTRL_CLEAR]);
    end
  end

  afc_pulse_gen #(.LOW_CYC(RSP_CYC), .REC_CYC(RSR_CYC)) u_clear (
    .pclk(pclk),
    .presetn(presetn),
    .start(clr_start),
    .out_n(clear_pulse_n),
    .busy(clr_busy)
  );

  // ========================================================================
  // Write port; data is set with the falling strobe and held to the next write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_data_in <= '0;
    end else if (wdata_wr) begin
      write_data_in <= pwdata[DATA_W-1:0];
    end
  end

  afc_strobe_port #(.PW_CYC(PW_CYC), .HOLD_CYC(FLOW_CYC), .REC_CYC(REC_CYC)) u_wr (
    .pclk(pclk),
    .presetn(presetn),
    .start(wdata_wr),
    .abort(clr_pending),
    .flag_n(full_flag_n),
    .strobe_n(write_strobe_n),
    .busy(wr_busy),
    .take(wr_take)
  );

  // Writes since the last clear, saturating at the rewind limit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcount <= '0;
    end else if (clr_start) begin
      wcount <= '0;
    end else if (wr_take && wcount != `AFC_WCOUNT_MAX) begin
      wcount <= wcount + 12'h001;
    end
  end

  // ========================================================================
  // Read port; reads wait out any rewind or clear in progress.
  assign rd_start = rd_pending && !rd_busy && !rwd_busy && !rwd_pending
                    && !clr_pending && !clr_busy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= (rd_pending && !rd_start) || (ctrl_wr && pwdata[`AFC_CTRL_READ]);
    end
  end

  afc_strobe_port #(.PW_CYC(RDPW_CYC), .HOLD_CYC(FLOW_CYC), .REC_CYC(REC_CYC)) u_rd (
    .pclk(pclk),
    .presetn(presetn),
    .start(rd_start),
    .abort(clr_pending),
    .flag_n(empty_flag_n),
    .strobe_n(read_strobe_n),
    .busy(rd_busy),
    .take(rd_take)
  );

  // Captured word and its valid flag; a new word wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
      rd_valid <= 1'b0;
    end else begin
      if (rd_take) begin
        rdata <= read_data_out;
      end
      rd_valid <= rd_take || (rd_valid && !rdata_rd);
    end
  end

  // ========================================================================
  // Rewind: standalone only and under the write limit, else refused.
  assign rwd_ok = !cascade && wcount < `AFC_WCOUNT_MAX;
  // The limit is checked again at the start, since a write may land while pending.
  assign rwd_start = rwd_pending && rwd_ok && !rd_busy && !clr_pending && !clr_busy
                     && !rwd_busy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rwd_pending <= 1'b0;
      rwd_refused <= 1'b0;
    end else begin
      rwd_pending <= (rwd_pending && !rwd_start && rwd_ok)
                     || (ctrl_wr && pwdata[`AFC_CTRL_REWIND] && rwd_ok);
      rwd_refused <= (ctrl_wr && pwdata[`AFC_CTRL_REWIND] && !rwd_ok)
                     || (rwd_refused && !(status_wr && pwdata[`AFC_ST_RWD_REFUSED]));
    end
  end

  afc_pulse_gen #(.LOW_CYC(RWD_CYC), .REC_CYC(RWD_REC_CYC)) u_rewind (
    .pclk(pclk),
    .presetn(presetn),
    .start(rwd_start),
    .out_n(rwd_pulse_n),
    .busy(rwd_busy)
  );

  assign rewind_strobe_n = cascade ? !LEAD_DEVICE : rwd_pulse_n;

  // ========================================================================
  // Checks on the pin sequences.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  clr_width_a: assert property ($fell(clear_pulse_n) |=> clear_pulse_n)
    else $error("clear pulse not one cycle wide");
  clr_quiet_a: assert property (!clear_pulse_n |-> write_strobe_n && read_strobe_n)
    else $error("strobe low during clear");
  wr_data_a: assert property (!write_strobe_n |=> $stable(write_data_in))
    else $error("write data moved while strobe low");
  wr_flow_a: assert property ($fell(write_strobe_n) && !$past(full_flag_n) ##1 !full_flag_n
    && clear_pulse_n && !clr_pending |-> !write_strobe_n)
    else $error("write strobe released while still full");
  rd_flow_a: assert property ($fell(read_strobe_n) && !$past(empty_flag_n) ##1 !empty_flag_n
    && !clr_pending |-> !read_strobe_n)
    else $error("read strobe released while still empty");
  rd_capture_a: assert property ($rose(read_strobe_n) && !$past(clr_pending)
    |-> rd_valid && rdata == $past(read_data_out))
    else $error("read word not captured at strobe rise");
  rwd_limit_a: assert property ($fell(rewind_strobe_n) && !cascade
    |-> $past(wcount) < `AFC_WCOUNT_MAX)
    else $error("rewind issued at write limit");
  rwd_read_a: assert property ($rose(rewind_strobe_n) && !cascade
    |-> read_strobe_n ##1 read_strobe_n)
    else $error("read during rewind recovery");
  casc_rwd_a: assert property (cascade ##1 cascade |-> $stable(rewind_strobe_n))
    else $error("rewind pin moved in cascade mode");
  wcount_a: assert property (wr_take && !clr_start && wcount != `AFC_WCOUNT_MAX
    |=> wcount == $past(wcount) + 12'h001)
    else $error("write count missed a write");

  wr_done_c: cover property ($rose(write_strobe_n) && wcount != '0);
  rd_done_c: cover property ($rose(rd_valid));
  wr_flow_c: cover property ($fell(write_strobe_n) && !full_flag_n ##[1:20] $rose(write_strobe_n));
  rwd_c: cover property ($fell(rewind_strobe_n) && !cascade);
endmodule : afc_host

// ### hw/afc_map.svh
// Register map, field positions and timing figures of the strobe FIFO host.
// Assumes a 40 MHz pclk and a device with 9-bit words and 2048 locations.
`ifndef AFC_MAP_SVH
`define AFC_MAP_SVH
// ==========================================================================
// Register offsets
`define AFC_ADDR_CTRL 8'h00
`define AFC_ADDR_STATUS 8'h04
`define AFC_ADDR_WDATA 8'h08
`define AFC_ADDR_RDATA 8'h0c
`define AFC_ADDR_WCOUNT 8'h10
// ==========================================================================
// Control bits, written as one-shot requests except the mode bit
`define AFC_CTRL_CLEAR 0
`define AFC_CTRL_REWIND 1
`define AFC_CTRL_READ 2
`define AFC_CTRL_CASCADE 3
// ==========================================================================
// Status bits
`define AFC_ST_EMPTY_N 0
`define AFC_ST_FULL_N 1
`define AFC_ST_HALF_N 2
`define AFC_ST_WR_BUSY 3
`define AFC_ST_RD_BUSY 4
`define AFC_ST_CLR_BUSY 5
`define AFC_ST_RWD_BUSY 6
`define AFC_ST_RD_VALID 7
`define AFC_ST_RWD_REFUSED 8
// ==========================================================================
// Word and counter sizes
`define AFC_DATA_W 9
`define AFC_WCOUNT_W 12
`define AFC_WCOUNT_MAX 12'h7ff
// ==========================================================================
// Times in ns
`define AFC_CLK_NS 25
`define AFC_T_PW_NS 15
`define AFC_T_REC_NS 10
`define AFC_T_ACC_NS 15
`define AFC_T_FLAG_NS 25
`define AFC_T_FLOW_NS 15
`define AFC_T_RSP_NS 15
`define AFC_T_RSR_NS 10
`define AFC_T_RWD_NS 15
`define AFC_T_RWD_REC_NS 10
`endif

// ### hw/afc_pkg.sv
// Types shared by the strobe FIFO host and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package afc_pkg;
  // ========================================================================
  // Strobe port states
  typedef enum logic [4:0] {
    PORT_IDLE = 5'h01,
    PORT_LOW = 5'h02,
    PORT_WAIT = 5'h04,
    PORT_HOLD = 5'h08,
    PORT_REC = 5'h10
  } afc_port_e;
  // Pulse generator states
  typedef enum logic [2:0] {
    PULSE_IDLE = 3'h1,
    PULSE_LOW = 3'h2,
    PULSE_REC = 3'h4
  } afc_pulse_e;
endpackage : afc_pkg

// ### hw/afc_pulse_gen.sv
// Low-going pulse of fixed width followed by a fixed recovery time.
// Assumes start is a one-cycle request; it is ignored while busy.
`timescale 1ns/1ps
module afc_pulse_gen #(
  parameter int LOW_CYC = 1,
  parameter int REC_CYC = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic out_n,
  output logic busy
);
  afc_pkg::afc_pulse_e state;
  logic [3:0] cnt;

  // ========================================================================
  // Sequencer: low for LOW_CYC cycles, then high and busy for REC_CYC.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= afc_pkg::PULSE_IDLE;
      cnt <= 4'h0;
      out_n <= 1'b1;
    end else begin
      case (state)
        afc_pkg::PULSE_IDLE: begin
          if (start) begin
            state <= afc_pkg::PULSE_LOW;
            out_n <= 1'b0;
            cnt <= 4'h0;
          end
        end
        afc_pkg::PULSE_LOW: begin
          if (cnt == 4'(LOW_CYC - 1)) begin
            state <= afc_pkg::PULSE_REC;
            out_n <= 1'b1;
            cnt <= 4'h0;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        afc_pkg::PULSE_REC: begin
          if (cnt == 4'(REC_CYC - 1)) begin
            state <= afc_pkg::PULSE_IDLE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        default: begin
          state <= afc_pkg::PULSE_IDLE;
          out_n <= 1'b1;
        end
      endcase
    end
  end

  // Busy covers both the pulse and its recovery.
  assign busy = (state != afc_pkg::PULSE_IDLE);
endmodule : afc_pulse_gen

// ### hw/afc_strobe_port.sv
// One strobe of the FIFO: a low pulse, with flow-through waiting when the
// gating flag was asserted at the falling edge, then a recovery time.
// Assumes flag_n is synchronous to pclk.
`timescale 1ns/1ps
module afc_strobe_port #(
  parameter int PW_CYC = 1,
  parameter int HOLD_CYC = 1,
  parameter int REC_CYC = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic abort,
  input wire logic flag_n,
  output logic strobe_n,
  output logic busy,
  output logic take
);
  afc_pkg::afc_port_e state;
  logic [3:0] cnt;
  logic blocked;

  // ========================================================================
  // Strobe sequencer; abort raises the strobe at once from any low state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= afc_pkg::PORT_IDLE;
      cnt <= 4'h0;
      strobe_n <= 1'b1;
      blocked <= 1'b0;
    end else begin
      case (state)
        afc_pkg::PORT_IDLE: begin
          if (start && !abort) begin
            state <= afc_pkg::PORT_LOW;
            strobe_n <= 1'b0;
            cnt <= 4'h0;
            blocked <= !flag_n;
          end
        end
        afc_pkg::PORT_LOW: begin
          if (abort || (cnt == 4'(PW_CYC - 1) && !blocked)) begin
            state <= afc_pkg::PORT_REC;
            strobe_n <= 1'b1;
            cnt <= 4'h0;
          end else if (cnt == 4'(PW_CYC - 1)) begin
            state <= afc_pkg::PORT_WAIT;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        afc_pkg::PORT_WAIT: begin
          if (abort) begin
            state <= afc_pkg::PORT_REC;
            strobe_n <= 1'b1;
            cnt <= 4'h0;
          end else if (flag_n) begin
            state <= afc_pkg::PORT_HOLD;
            cnt <= 4'h0;
          end
        end
        afc_pkg::PORT_HOLD: begin
          if (abort || cnt == 4'(HOLD_CYC - 1)) begin
            state <= afc_pkg::PORT_REC;
            strobe_n <= 1'b1;
            cnt <= 4'h0;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        afc_pkg::PORT_REC: begin
          if (cnt == 4'(REC_CYC - 1)) begin
            state <= afc_pkg::PORT_IDLE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        default: begin
          state <= afc_pkg::PORT_IDLE;
          strobe_n <= 1'b1;
        end
      endcase
    end
  end

  // Take marks the cycle whose closing edge raises the strobe normally.
  assign busy = (state != afc_pkg::PORT_IDLE);
  assign take = !abort && ((state == afc_pkg::PORT_LOW && cnt == 4'(PW_CYC - 1) && !blocked)
                || (state == afc_pkg::PORT_HOLD && cnt == 4'(HOLD_CYC - 1)));
endmodule : afc_strobe_port

// ### tb/afc_fifo_model.sv
// Behavioural strobed FIFO device that answers the host controller.
// Assumes standalone operation and strobes driven by the host.
`timescale 1ns/1ps
module afc_fifo_model #(
  parameter int DEPTH = 2048
) (
  input wire logic write_strobe_n,
  input wire logic [8:0] write_data_in,
  input wire logic read_strobe_n,
  output logic [8:0] read_data_out,
  input wire logic clear_pulse_n,
  input wire logic rewind_strobe_n,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic half_level_flag_n
);
  // ==========================================================================
  // Storage and occupancy.
  logic [8:0] mem [DEPTH];
  int wp = 0;
  int rp = 0;
  int cnt = 0;
  bit wr_on = 0;
  bit rd_on = 0;
  // chain input grounded, so no chain pulses or pointer passing.
  initial begin
    {empty_flag_n, full_flag_n, half_level_flag_n} = 3'h3;
    read_data_out = 9'h0aa;
  end
  always @(negedge clear_pulse_n) begin
    {wp, rp, cnt, wr_on, rd_on} = '0;
    {empty_flag_n, full_flag_n, half_level_flag_n} = 3'h3;
  end
  always @(negedge rewind_strobe_n) begin
    rp = 0;
    cnt = wp;
    {empty_flag_n, full_flag_n, half_level_flag_n} = {cnt != 0, cnt != DEPTH, cnt <= DEPTH / 2};
  end
  // write start, gated by the full flag.
  always @(negedge write_strobe_n) begin
    if (full_flag_n) begin
      wr_on = 1;
      cnt++;
      full_flag_n = (cnt != DEPTH);
      half_level_flag_n = (cnt <= DEPTH / 2);
    end
  end
  // data taken at the rise; a held read flows through.
  always @(posedge write_strobe_n) begin
    if (wr_on) begin
      mem[wp] = write_data_in;
      wp = (wp + 1) % DEPTH;
      wr_on = 0;
      empty_flag_n = 1;
      full_flag_n = (cnt != DEPTH);
      if (!read_strobe_n && !rd_on) begin
        rd_on = 1;
        cnt--;
        read_data_out = mem[rp];
      end
    end
  end
  // read start, gated by the empty flag.
  always @(negedge read_strobe_n) begin
    if (empty_flag_n) begin
      rd_on = 1;
      cnt--;
      read_data_out = mem[rp];
      empty_flag_n = (cnt != 0);
    end
  end
  // read end; released outputs change; a held write flows through.
  always @(posedge read_strobe_n) begin
    if (rd_on) begin
      rp = (rp + 1) % DEPTH;
      rd_on = 0;
      read_data_out = ~read_data_out;
      {empty_flag_n, full_flag_n, half_level_flag_n} = {cnt != 0, cnt != DEPTH, cnt <= DEPTH / 2};
      if (!write_strobe_n && !wr_on) begin
        wr_on = 1;
        cnt++;
      end
    end
  end
endmodule : afc_fifo_model

// ### tb/afc_host_test.sv
// Self-checking bench for the strobe FIFO host against a device model.
// Assumes afc_host and afc_fifo_model are compiled before it.
`timescale 1ns/1ps
`include "afc_map.svh"
module afc_host_test;
  // ==========================================================================
  // Signals and counters.
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, d;
  logic ws_n, rstb_n, clr_n, rw_n, empty_n, full_n, half_n;
  logic [8:0] wd, rd, w [3];
  logic [8:0] q [$];
  int n_errors = 0, n_tests = 0, cycles = 0, i, seed = 32'h2172;
  always #12.5 pclk = ~pclk;
  afc_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .write_strobe_n(ws_n), .write_data_in(wd), .read_strobe_n(rstb_n),
    .read_data_out(rd), .clear_pulse_n(clr_n), .rewind_strobe_n(rw_n),
    .empty_flag_n(empty_n), .full_flag_n(full_n), .half_level_flag_n(half_n));
  afc_fifo_model u_fifo (.write_strobe_n(ws_n), .write_data_in(wd), .read_strobe_n(rstb_n),
    .read_data_out(rd), .clear_pulse_n(clr_n), .rewind_strobe_n(rw_n),
    .empty_flag_n(empty_n), .full_flag_n(full_n), .half_level_flag_n(half_n));
  // ==========================================================================
  // Helpers: compare, bus cycle, waits and word transfers.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_st(input int b, input logic v);
    for (int k = 0; k < 100 && !(k > 0 && r[b] === v); k++) apb(0, `AFC_ADDR_STATUS, 0);
    chk("status bit", r[b], v);
  endtask : wait_st
  function automatic logic [2:0] flags_for(input int n);
    return {n <= 1024, n != 2048, n != 0};
  endfunction : flags_for
  task automatic chk_flags(input int n);
    apb(0, `AFC_ADDR_STATUS, 0);
    chk("flags", r[2:0], flags_for(n));
  endtask : chk_flags
  task automatic push(input logic [8:0] v);
    apb(1, `AFC_ADDR_WDATA, {23'h0, v});
    wait_st(`AFC_ST_WR_BUSY, 1'b0);
  endtask : push
  task automatic collect(input logic [8:0] v);
    wait_st(`AFC_ST_RD_VALID, 1'b1);
    apb(0, `AFC_ADDR_RDATA, 0);
    chk("read word", r[8:0], v);
  endtask : collect
  task automatic pop(input logic [8:0] v);
    apb(1, `AFC_ADDR_CTRL, 32'h4);
    collect(v);
  endtask : pop
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // Hang guard sized for about forty-three thousand cycles of traffic.
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 95000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ==========================================================================
  // Scenarios.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_st(`AFC_ST_CLR_BUSY, 1'b0);
    chk_flags(0);
    $display("test reset done");
    apb(1, `AFC_ADDR_CTRL, 32'h4);
    d = $random(seed);
    push(d[8:0]);
    collect(d[8:0]);
    chk_flags(0);
    $display("test flow read done");
    for (i = 0; i < 2048; i++) begin
      d = (i == 0) ? 32'h1ff : $random(seed);
      q.push_back(d[8:0]);
      push(d[8:0]);
      if (i == 1023 || i == 1024 || i == 2047) chk_flags(i + 1);
    end
    apb(0, `AFC_ADDR_WCOUNT, 0);
    chk("write count", r[11:0], 12'h7ff);
    apb(1, `AFC_ADDR_CTRL, 32'h2);
    apb(0, `AFC_ADDR_STATUS, 0);
    chk("rewind refused", r[8], 1'b1);
    d = $random(seed);
    q.push_back(d[8:0]);
    apb(1, `AFC_ADDR_WDATA, {23'h0, d[8:0]});
    repeat (3) @(posedge pclk);
    chk("held write strobe", ws_n, 1'b0);
    for (i = 2049; i > 0; i--) begin
      pop(q.pop_front());
      if (i == 2049) wait_st(`AFC_ST_WR_BUSY, 1'b0);
      if (i == 1026 || i == 1025) chk_flags(i - 1);
    end
    chk_flags(0);
    $display("test fill and drain done");
    apb(1, `AFC_ADDR_CTRL, 32'h1);
    wait_st(`AFC_ST_CLR_BUSY, 1'b0);
    for (i = 0; i < 3; i++) begin
      d = $random(seed);
      w[i] = d[8:0];
      push(w[i]);
    end
    pop(w[0]);
    pop(w[1]);
    apb(1, `AFC_ADDR_CTRL, 32'h2);
    wait_st(`AFC_ST_RWD_BUSY, 1'b0);
    chk_flags(3);
    for (i = 0; i < 3; i++) pop(w[i]);
    chk_flags(0);
    $display("test rewind done");
    apb(1, `AFC_ADDR_STATUS, 32'h100);
    apb(0, `AFC_ADDR_STATUS, 0);
    chk("refused cleared", r[8], 1'b0);
    apb(1, `AFC_ADDR_CTRL, 32'h8);
    apb(1, `AFC_ADDR_CTRL, 32'ha);
    apb(0, `AFC_ADDR_STATUS, 0);
    chk("cascade rewind refused", r[8], 1'b1);
    chk("cascade half", r[2], 1'b1);
    chk("lead select", rw_n, 1'b0);
    apb(0, `AFC_ADDR_CTRL, 0);
    chk("cascade mode", r[3], 1'b1);
    apb(1, `AFC_ADDR_CTRL, 32'h0);
    $display("test cascade done");
    apb(0, 8'h20, 0);
    chk("unmapped data", r, 32'h0);
    chk("unmapped error", e, 1'b1);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule : afc_host_test
